// >>> design/bbnr_pkg.sv
// constants for the bridge bus number and i/o window register bank
package bbnr_pkg;
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] BBNR_OFF_BUSNUM = 8'h18;
  localparam logic [7:0] BBNR_OFF_IOWIN = 8'h1C;
  localparam logic [7:0] BBNR_OFF_IOUPPER = 8'h30;
  localparam logic [7:0] BBNR_OFF_LATSTAT = 8'h40;
  // ****************************************
  // field positions
  // ****************************************
  localparam int BBNR_SEC_BUS_LSB = 8;
  localparam int BBNR_SUB_BUS_LSB = 16;
  localparam int BBNR_LAT_LSB = 24;
  localparam int BBNR_IO_BASE_LSB = 4;
  localparam int BBNR_IO_LIM_LSB = 12;
  localparam int BBNR_IO_BASE_IND_LSB = 0;
  localparam int BBNR_IO_LIM_IND_LSB = 8;
  localparam int BBNR_IOUP_BASE_LSB = 0;
  localparam int BBNR_IOUP_LIM_LSB = 16;
  localparam int BBNR_STAT_EXP_BIT = 8;
  localparam int BBNR_STAT_ACT_BIT = 9;
  localparam int BBNR_STAT_STOP_BIT = 10;
  // ****************************************
  // values after reset and fixed values
  // ****************************************
  localparam logic [7:0] BBNR_BUS_RESET = 8'h00;
  localparam logic [7:0] BBNR_LAT_RESET = 8'h00;
  localparam logic [3:0] BBNR_IO_NIB_RESET = 4'h0;
  localparam logic [15:0] BBNR_IOUP_RESET = 16'h0000;
  localparam logic [3:0] BBNR_IO32_IND = 4'h1;
  localparam logic [11:0] BBNR_IO_BASE_LOW = 12'h000;
  localparam logic [11:0] BBNR_IO_LIM_LOW = 12'hFFF;
  localparam logic [31:0] BBNR_WORD_RESET = 32'h0000_0000;
endpackage : bbnr_pkg

// >>> design/bbnr_regs.sv
// bridge bus number, secondary latency timer and i/o window registers
`timescale 1ns/10ps
`default_nettype none

// Function
// - read-write secondary bus number at bits 15:8, reset zero
// - read-write highest downstream bus number at bits 23:16, reset zero
// - read-write secondary latency timer at 31:24 counts clocks from frame start
// - timer zero and grant removed: end after first transfer, except memory write invalidate
// - low nibbles of i/o base and limit bytes read one
// - i/o base nibble gives address 15:12, low bits zero, reset zero
// - i/o limit nibble gives address 15:12, low bits all ones, reset zero
// - i/o address inside base..limit range is forwarded
// - address bits 31:16 of base and limit come from upper registers
module bbnr_regs
  import bbnr_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // secondary master engine, same clock
  input wire logic sec_frame_start,
  input wire logic sec_master_active,
  input wire logic sec_first_xfer_done,
  input wire logic sec_mwi,
  // secondary grant pin, active low, asynchronous
  input wire logic sec_gnt_n,
  output logic sec_master_stop,
  // i/o forwarding decision
  input wire logic io_check,
  input wire logic [31:0] io_addr,
  output logic io_fwd_valid,
  output logic io_fwd_hit,
  // programmed bus numbers for routing logic
  output logic [7:0] sec_bus_number,
  output logic [7:0] sub_bus_number
);

  // ****************************************
  // apb decode and register storage
  // ****************************************
  logic [7:0] sec_bus_q, sec_bus_d;
  logic [7:0] sub_bus_q, sub_bus_d;
  logic [7:0] lat_q, lat_d;
  logic [3:0] io_base_q, io_base_d;
  logic [3:0] io_lim_q, io_lim_d;
  logic [15:0] io_base_up_q, io_base_up_d;
  logic [15:0] io_lim_up_q, io_lim_up_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic done;
  logic wr;
  logic hit_busnum, hit_iowin, hit_ioup, hit_stat, mapped;
  logic [31:0] rd_word;

  // latency timer and grant state
  logic [7:0] cnt_q, cnt_d;
  logic expired_q, expired_d;
  logic stop_q, stop_d;
  logic gnt_meta_q, gnt_sync_q;

  // window decision state
  logic fwd_valid_q, fwd_valid_d;
  logic fwd_hit_q, fwd_hit_d;
  logic [31:0] win_base, win_lim;

  // the answer flop doubles as the wait state: a second access phase
  // cannot be answered until the first answer has dropped
  // address decode, one wait state per access
  always_comb begin
    hit_busnum = (paddr == BBNR_OFF_BUSNUM);
    hit_iowin = (paddr == BBNR_OFF_IOWIN);
    hit_ioup = (paddr == BBNR_OFF_IOUPPER);
    hit_stat = (paddr == BBNR_OFF_LATSTAT);
    mapped = hit_busnum | hit_iowin | hit_ioup | hit_stat;
    done = psel & penable & pready_q;
    wr = done & pwrite & mapped;
  end

  // read word assembly; unused bytes read as zero
  always_comb begin
    rd_word = BBNR_WORD_RESET;
    if (hit_busnum) begin
      rd_word[BBNR_SEC_BUS_LSB +: 8] = sec_bus_q;
      rd_word[BBNR_SUB_BUS_LSB +: 8] = sub_bus_q;
      rd_word[BBNR_LAT_LSB +: 8] = lat_q;
    end else if (hit_iowin) begin
      rd_word[BBNR_IO_BASE_IND_LSB +: 4] = BBNR_IO32_IND;
      rd_word[BBNR_IO_LIM_IND_LSB +: 4] = BBNR_IO32_IND;
      rd_word[BBNR_IO_BASE_LSB +: 4] = io_base_q;
      rd_word[BBNR_IO_LIM_LSB +: 4] = io_lim_q;
    end else if (hit_ioup) begin
      rd_word[BBNR_IOUP_BASE_LSB +: 16] = io_base_up_q;
      rd_word[BBNR_IOUP_LIM_LSB +: 16] = io_lim_up_q;
    end else if (hit_stat) begin
      rd_word[7:0] = cnt_q;
      rd_word[BBNR_STAT_EXP_BIT] = expired_q;
      rd_word[BBNR_STAT_ACT_BIT] = sec_master_active;
      rd_word[BBNR_STAT_STOP_BIT] = stop_q;
    end
  end

  // reads of a write return zero so stale data never looks like an answer
  // bus answer: pready pulses one cycle after the access phase opens
  always_comb begin
    pready_d = psel & penable & ~pready_q;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    if (pready_d) begin
      prdata_d = pwrite ? BBNR_WORD_RESET : rd_word;
      pslverr_d = ~mapped;
    end
  end

  // writes land only at the completing edge; a master that drops its
  // request early leaves every field untouched
  // register writes, per byte lane; the indicator nibbles are not stored
  always_comb begin
    sec_bus_d = sec_bus_q;
    sub_bus_d = sub_bus_q;
    lat_d = lat_q;
    io_base_d = io_base_q;
    io_lim_d = io_lim_q;
    io_base_up_d = io_base_up_q;
    io_lim_up_d = io_lim_up_q;
    if (wr && hit_busnum) begin
      if (pstrb[1]) begin
        sec_bus_d = pwdata[BBNR_SEC_BUS_LSB +: 8];
      end
      if (pstrb[2]) begin
        sub_bus_d = pwdata[BBNR_SUB_BUS_LSB +: 8];
      end
      if (pstrb[3]) begin
        lat_d = pwdata[BBNR_LAT_LSB +: 8];
      end
    end
    if (wr && hit_iowin) begin
      if (pstrb[0]) begin
        io_base_d = pwdata[BBNR_IO_BASE_LSB +: 4];
      end
      if (pstrb[1]) begin
        io_lim_d = pwdata[BBNR_IO_LIM_LSB +: 4];
      end
    end
    if (wr && hit_ioup) begin
      if (pstrb[0]) begin
        io_base_up_d[7:0] = pwdata[7:0];
      end
      if (pstrb[1]) begin
        io_base_up_d[15:8] = pwdata[15:8];
      end
      if (pstrb[2]) begin
        io_lim_up_d[7:0] = pwdata[23:16];
      end
      if (pstrb[3]) begin
        io_lim_up_d[15:8] = pwdata[31:24];
      end
    end
  end

  // register bank and bus answer flops
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sec_bus_q <= BBNR_BUS_RESET;
      sub_bus_q <= BBNR_BUS_RESET;
      lat_q <= BBNR_LAT_RESET;
      io_base_q <= BBNR_IO_NIB_RESET;
      io_lim_q <= BBNR_IO_NIB_RESET;
      io_base_up_q <= BBNR_IOUP_RESET;
      io_lim_up_q <= BBNR_IOUP_RESET;
      prdata_q <= BBNR_WORD_RESET;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      sec_bus_q <= sec_bus_d;
      sub_bus_q <= sub_bus_d;
      lat_q <= lat_d;
      io_base_q <= io_base_d;
      io_lim_q <= io_lim_d;
      io_base_up_q <= io_base_up_d;
      io_lim_up_q <= io_lim_up_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ****************************************
  // secondary grant synchroniser
  // ****************************************
  // the first flop may go metastable; only the second feeds logic
  // reset to removed so a stop decision never trusts an unknown grant
  // grant arrives from the arbiter pin, so two flops before use
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gnt_meta_q <= 1'b1;
      gnt_sync_q <= 1'b1;
    end else begin
      gnt_meta_q <= sec_gnt_n;
      gnt_sync_q <= gnt_meta_q;
    end
  end

  // ****************************************
  // secondary master latency timer
  // ****************************************
  // the count is loaded only at the frame, so a mid-transaction change sets the next count;
  // the zero-timer gate on stop reads the value every cycle and can still act on this one
  // grant sync adds two clocks of delay before a stop can follow
  always_comb begin
    cnt_d = cnt_q;
    expired_d = expired_q;
    if (sec_frame_start) begin
      cnt_d = lat_q;
      expired_d = (lat_q == BBNR_LAT_RESET);
    end else if (sec_master_active && !expired_q) begin
      cnt_d = cnt_q - 8'h01;
      expired_d = (cnt_q == 8'h01);
    end
    // stop once grant gone and timer out
    stop_d = sec_master_active & expired_q & gnt_sync_q & ~sec_mwi;
    // a zero timer still lets the first data phase complete
    if (lat_q == BBNR_LAT_RESET) begin
      stop_d = stop_d & sec_first_xfer_done;
    end
  end

  // timer flops; count holds after the frame for software to read
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= BBNR_LAT_RESET;
      expired_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      expired_q <= expired_d;
      stop_q <= stop_d;
    end
  end

  // ****************************************
  // i/o forwarding window
  // ****************************************
  // unsigned 32-bit compare; a limit below the base leaves the window
  // empty rather than wrapping around
  always_comb begin
    win_base = {io_base_up_q, io_base_q, BBNR_IO_BASE_LOW};
    win_lim = {io_lim_up_q, io_lim_q, BBNR_IO_LIM_LOW};
    fwd_valid_d = io_check;
    fwd_hit_d = fwd_hit_q;
    // range compare; limit below base never hits
    if (io_check) begin
      fwd_hit_d = (io_addr >= win_base) && (io_addr <= win_lim);
    end
  end

  // decision flops, one cycle after the check strobe
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fwd_valid_q <= 1'b0;
      fwd_hit_q <= 1'b0;
    end else begin
      fwd_valid_q <= fwd_valid_d;
      fwd_hit_q <= fwd_hit_d;
    end
  end

  // ****************************************
  // outputs, all from flops
  // registered so routing logic never sees a decode glitch
  // ****************************************
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign sec_master_stop = stop_q;
  assign io_fwd_valid = fwd_valid_q;
  assign io_fwd_hit = fwd_hit_q;
  assign sec_bus_number = sec_bus_q;
  assign sub_bus_number = sub_bus_q;

endmodule // bbnr_regs

`default_nettype wire

// >>> verification/bbnr_monitor.sv
// assertion checker for the bus number and i/o window registers
`timescale 1ns/10ps
`default_nettype none
module bbnr_monitor
  import bbnr_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sec_mwi,
  input wire logic sec_master_active,
  input wire logic sec_gnt_n,
  input wire logic sec_master_stop,
  input wire logic io_check,
  input wire logic io_fwd_valid,
  input wire logic [7:0] sec_bus_number,
  input wire logic [7:0] sub_bus_number
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // completed transfer and mapped offset
  logic done;
  logic hit;
  assign done = psel && penable && pready;
  assign hit = paddr inside {BBNR_OFF_BUSNUM, BBNR_OFF_IOWIN, BBNR_OFF_IOUPPER, BBNR_OFF_LATSTAT};
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence wr_bus_s;
    done && pwrite && paddr == BBNR_OFF_BUSNUM;
  endsequence
  one_wait_a: assert property (setup_s ##1 (psel && penable) |-> !pready ##1 pready) else $error("wait state");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  unmapped_err_a: assert property (done && !hit |-> pslverr) else $error("no error");
  mapped_ok_a: assert property (done && hit |-> !pslverr) else $error("mapped error");
  valid_pulse_a: assert property (!io_check |=> !io_fwd_valid) else $error("io valid held");
  ind_read_a: assert property (done && !pwrite && paddr == BBNR_OFF_IOWIN |->
    prdata[3:0] == BBNR_IO32_IND && prdata[11:8] == BBNR_IO32_IND) else $error("indicator");
  sec_bus_a: assert property (wr_bus_s ##0 pstrb[1] |=> sec_bus_number == $past(pwdata[15:8])) else $error("sec");
  sub_bus_a: assert property (wr_bus_s ##0 pstrb[2] |=> sub_bus_number == $past(pwdata[23:16])) else $error("sub");
  io_answer_a: assert property (io_check |=> io_fwd_valid) else $error("io answer");
  mwi_stop_a: assert property (sec_mwi [*3] |-> !sec_master_stop) else $error("mwi stop");
  grant_stop_a: assert property (!sec_gnt_n [*5] |-> !sec_master_stop) else $error("grant stop");
  idle_stop_a: assert property (!sec_master_active [*2] |-> !sec_master_stop) else $error("idle stop");
endmodule // bbnr_monitor
bind bbnr_regs bbnr_monitor mon_u (
  .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sec_mwi(sec_mwi), .sec_master_active(sec_master_active),
  .sec_gnt_n(sec_gnt_n), .sec_master_stop(sec_master_stop), .io_check(io_check),
  .io_fwd_valid(io_fwd_valid), .sec_bus_number(sec_bus_number), .sub_bus_number(sub_bus_number)
);
`default_nettype wire

// >>> verification/bbnr_sec_master.sv
// behavioural secondary master engine and grant source
`timescale 1ns/10ps
`default_nettype none
module bbnr_sec_master (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic go,
  input wire logic go_mwi,
  input wire logic gnt_off,
  input wire logic sec_master_stop,
  output logic sec_frame_start,
  output logic sec_master_active,
  output logic sec_first_xfer_done,
  output logic sec_mwi,
  output logic sec_gnt_n,
  output logic [7:0] cycles
);
  // one transaction per go; a cap of 40 clocks stands in for a long burst
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      {sec_frame_start, sec_master_active, sec_first_xfer_done, sec_mwi} <= 4'h0;
      sec_gnt_n <= 1'b1;
      cycles <= 8'h00;
    end else begin
      sec_gnt_n <= gnt_off;
      sec_frame_start <= go;
      if (go) begin
        sec_master_active <= 1'b1;
        sec_mwi <= go_mwi;
        cycles <= 8'h00;
      end else if (sec_master_active) begin
        sec_first_xfer_done <= 1'b1;
        if (sec_master_stop || cycles == 8'h28) begin
          sec_master_active <= 1'b0;
          sec_first_xfer_done <= 1'b0;
        end else begin
          cycles <= cycles + 8'h01;
        end
      end
    end
  end
endmodule // bbnr_sec_master
`default_nettype wire

// >>> verification/bbnr_regs_bench.sv
// self-checking bench for the bus number and i/o window registers
`timescale 1ns/10ps
`default_nettype none
module bbnr_regs_bench
  import bbnr_pkg::*;
;
  logic clock = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, io_check = 0, go = 0, go_mwi = 0, gnt_off = 1;
  logic [7:0] paddr = '0, sec_bus_number, sub_bus_number, cycles;
  logic [3:0] pstrb = '0, bn, ln;
  logic [31:0] pwdata = '0, io_addr = '0, prdata, r, d, q, up;
  logic pready, pslverr, e, io_fwd_valid, io_fwd_hit, sec_master_stop;
  logic sec_frame_start, sec_master_active, sec_first_xfer_done, sec_mwi, sec_gnt_n;
  logic [7:0] lt [4] = '{8'h02, 8'h00, 8'h03, 8'h01};
  int mismatches = 0, compares = 0;
  bbnr_regs dut_u (
    .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sec_frame_start(sec_frame_start), .sec_master_active(sec_master_active),
    .sec_first_xfer_done(sec_first_xfer_done), .sec_mwi(sec_mwi), .sec_gnt_n(sec_gnt_n),
    .sec_master_stop(sec_master_stop), .io_check(io_check), .io_addr(io_addr),
    .io_fwd_valid(io_fwd_valid), .io_fwd_hit(io_fwd_hit), .sec_bus_number(sec_bus_number),
    .sub_bus_number(sub_bus_number)
  );
  bbnr_sec_master peer_u (
    .clock(clock), .reset_n(reset_n), .go(go), .go_mwi(go_mwi), .gnt_off(gnt_off),
    .sec_master_stop(sec_master_stop), .sec_frame_start(sec_frame_start),
    .sec_master_active(sec_master_active), .sec_first_xfer_done(sec_first_xfer_done),
    .sec_mwi(sec_mwi), .sec_gnt_n(sec_gnt_n), .cycles(cycles)
  );
  // bus clock
  always #20 clock = ~clock;
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {1'b1, 1'b0, w, a, wd, s};
    @(posedge clock);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a wait
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
    @(posedge clock);
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask
  // window test: low bits zero at base, all ones at limit
  function automatic logic io_win(input logic [31:0] a);
    return a >= {up[15:0], bn, 12'h000} && a <= {up[31:16], ln, 12'hFFF};
  endfunction
  // lookup answers one clock after the check
  task automatic probe(input logic [31:0] a);
    {io_check, io_addr} <= {1'b1, a};
    @(posedge clock);
    io_check <= 1'b0;
    @(posedge clock);
    chk("io_valid", 32'h1, {31'h0, io_fwd_valid});
    chk("io_hit", {31'h0, io_win(a)}, {31'h0, io_fwd_hit});
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    void'($urandom(32'hE524));
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    apb(1'b0, BBNR_OFF_BUSNUM, '0, 4'h0);
    chk("bus_reset", BBNR_WORD_RESET, r);
    apb(1'b0, BBNR_OFF_IOWIN, '0, 4'h0);
    chk("io_reset", 32'h0000_0101, r);
    q = '0;
    // full writes, then one single-lane write that must leave the rest alone
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      d[23:16] = d[23:16] | ((i == 3) ? q[15:8] : d[15:8]);
      apb(1'b1, BBNR_OFF_BUSNUM, d, (i == 3) ? 4'h4 : 4'hF);
      q = (i == 3) ? {q[31:24], d[23:16], q[15:0]} : (d & 32'hFFFF_FF00);
      apb(1'b0, BBNR_OFF_BUSNUM, '0, 4'h0);
      chk("bus_word", q, r);
      chk("sec_bus", {24'h0, q[15:8]}, {24'h0, sec_bus_number});
      chk("sub_bus", {24'h0, q[23:16]}, {24'h0, sub_bus_number});
      chk("mapped_err", 32'h0, {31'h0, e});
    end
    apb(1'b1, 8'h24, 32'hFFFF_FFFF, 4'hF);
    chk("unmapped_err", 32'h1, {31'h0, e});
    apb(1'b0, 8'h24, '0, 4'h0);
    chk("unmapped_rd", 32'h0, r);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      up = $urandom;
      d = $urandom;
      // limit kept at or above base
      up[31:16] = up[31:16] | up[15:0];
      bn = d[7:4];
      ln = d[15:12] | ((up[31:16] == up[15:0]) ? bn : 4'h0);
      apb(1'b1, BBNR_OFF_IOUPPER, up, 4'hF);
      apb(1'b1, BBNR_OFF_IOWIN, {d[31:16], ln, d[11:8], bn, d[3:0]}, 4'hF);
      apb(1'b0, BBNR_OFF_IOWIN, '0, 4'h0);
      chk("io_word", {16'h0, ln, 4'h1, bn, 4'h1}, r);
      apb(1'b0, BBNR_OFF_IOUPPER, '0, 4'h0);
      chk("io_upper", up, r);
      probe({up[15:0], bn, 12'h000});
      probe({up[15:0], bn, 12'h000} - 32'h1);
      probe({up[31:16], ln, 12'hFFF});
      probe({up[31:16], ln, 12'hFFF} + 32'h1);
      probe($urandom);
    end
    $display("test io window done");
    // timer value 2, value 0, mwi, grant held
    for (int i = 0; i < 4; i++) begin
      {go_mwi, gnt_off} <= {i == 2, i != 3};
      apb(1'b1, BBNR_OFF_BUSNUM, {lt[i], 24'h0}, 4'h8);
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      repeat (2) @(posedge clock);
      for (int k = 0; k < 60 && sec_master_active === 1'b1; k++) @(posedge clock);
      if (i < 2) chk("stop_time", 32'h1, {31'h0, cycles >= lt[i] && cycles <= lt[i] + 8'h05});
      else chk("no_stop", 32'h28, {24'h0, cycles});
      apb(1'b0, BBNR_OFF_LATSTAT, '0, 4'h0);
      // count run out and expired, master idle, stop dropped
      chk("timer_stat", 32'h0000_0100, r);
    end
    $display("test latency done");
    // reset in mid-run must bring every field back to its reset value
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    apb(1'b0, BBNR_OFF_BUSNUM, '0, 4'h0);
    chk("rst_bus", BBNR_WORD_RESET, r);
    chk("rst_sec", 32'h0, {24'h0, sec_bus_number});
    chk("rst_sub", 32'h0, {24'h0, sub_bus_number});
    apb(1'b0, BBNR_OFF_IOWIN, '0, 4'h0);
    chk("rst_io", 32'h0000_0101, r);
    apb(1'b0, BBNR_OFF_IOUPPER, '0, 4'h0);
    chk("rst_upper", 32'h0, r);
    apb(1'b0, BBNR_OFF_LATSTAT, '0, 4'h0);
    chk("rst_stat", 32'h0, r);
    up = '0;
    bn = '0;
    ln = '0;
    // window after reset covers the first 4 KiB only
    probe(32'h0000_0FFF);
    probe(32'h0000_1000);
    $display("test reset done");
    end_of_test();
  end
  // watchdog, far beyond the few hundred clocks the tests need
  initial begin
    #400000;
    mismatches++;
    end_of_test();
  end
endmodule // bbnr_regs_bench
`default_nettype wire
